// file: hw/rl_parser.sv
// return link and table update descriptor parser with an axi4-lite register slave
// assumes a byte stream synchronous to ref_clk_in, one descriptor after another
//
// Overview of operation
// R1: first byte is the kind code selecting the layout
// R2: second byte counts body bytes and bounds body decoding
// R3: return link body decoded msb first in fixed field order
// R4: reserved bits skipped and never affect results
// R5: sender randomises reserved bits in encrypted unicast messages
// R6: spacecraft number captured as the carrying satellite
// R7: spot number captured as the carrying beam
// R8: hub station number captured as receiving ground station
// R9: orbital slot kept as four bcd digits, point after third
// R10: hemisphere bit 0 west, 1 east
// R11: frame group select captured for frame group table matching
// R12: frequency shift signed 24 bit in 100 hz steps
// R13: frequency shift not applied when message is broadcast
// R14: bytes past fixed fields passed out as vendor bytes
// R15: update body is network number then code and revision pairs
// R16: each table kind code flags an imminent table change
// R17: 5 bit revision captured as the table's next version
// R18: table update notices may be discarded entirely
// R19: header version tracking is left untouched by notices
// R20: table kind codes are not filtered to any table family
// R21: network sends no notice for whole-period start time moves
// R22: entry pulses let the scan logic restrict table scanning
// R23: entry count follows byte count; trailing half entry dropped
`default_nettype none
`include "rl_parser_defines.svh"

module rl_parser (
  input  wire logic        ref_clk_in,          // 50 mhz clock
  input  wire logic        rst_n_in,            // async reset, active low
  input  wire logic [7:0]  awaddr_in,           // write address
  input  wire logic        awvalid_in,          // write address valid
  output logic             awready_out,         // write address ready
  input  wire logic [31:0] wdata_in,            // write data
  input  wire logic [3:0]  wstrb_in,            // write byte strobes
  input  wire logic        wvalid_in,           // write data valid
  output logic             wready_out,          // write data ready
  output logic [1:0]       bresp_out,           // write response
  output logic             bvalid_out,          // write response valid
  input  wire logic        bready_in,           // write response ready
  input  wire logic [7:0]  araddr_in,           // read address
  input  wire logic        arvalid_in,          // read address valid
  output logic             arready_out,         // read address ready
  output logic [31:0]      rdata_out,           // read data
  output logic [1:0]       rresp_out,           // read response
  output logic             rvalid_out,          // read data valid
  input  wire logic        rready_in,           // read data ready
  input  wire logic [7:0]  byte_in,             // descriptor byte
  input  wire logic        byte_valid_in,       // byte strobe
  input  wire logic        restart_in,          // next byte is a kind code
  input  wire logic        broadcast_in,        // current message is broadcast
  output logic [7:0]       spacecraft_number_out,  // carrying satellite
  output logic [15:0]      spot_number_out,     // carrying beam
  output logic [7:0]       hub_station_number_out, // receiving station
  output logic [15:0]      orbital_slot_out,    // four bcd digits
  output logic             hemisphere_east_out, // 1 east, 0 west
  output logic [7:0]       frame_group_select_out, // superframe label
  output logic [23:0]      freq_shift_out,      // signed, 100 hz steps
  output logic             freq_shift_apply_out,// shift may be applied
  output logic             rl_done_out,         // return link fields updated
  output logic [7:0]       vendor_byte_out,     // opaque vendor byte
  output logic             vendor_valid_out,    // vendor byte strobe
  output logic [15:0]      network_number_out,  // network of the notice
  output logic [7:0]       table_kind_code_out, // table about to change
  output logic [4:0]       revision_out,        // its next version
  output logic             entry_valid_out      // update entry strobe
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  rl_parser_pkg::parse_state_t state_reg;
  rl_parser_pkg::desc_kind_t   kind_reg;
  logic [7:0]  rem_reg;
  logic [7:0]  idx_reg;
  logic [1:0]  ctrl_reg;
  logic [7:0]  kind_rl_reg;
  logic [7:0]  kind_upd_reg;
  logic [7:0]  sc_work_reg;
  logic [15:0] spot_work_reg;
  logic [7:0]  hub_work_reg;
  logic [15:0] slot_work_reg;
  logic        east_work_reg;
  logic [7:0]  frame_work_reg;
  logic [15:0] shift_work_reg;
  logic [7:0]  code_work_reg;
  logic [7:0]  rl_count_reg;
  logic [7:0]  entry_count_reg;
  logic [7:0]  partial_count_reg;
  logic        aw_have_reg;
  logic        w_have_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        body_byte;
  logic        body_last;

  assign body_byte = byte_valid_in && !restart_in && (state_reg == rl_parser_pkg::ST_BODY);
  assign body_last = body_byte && (rem_reg == 8'h01);

  function automatic rl_parser_pkg::desc_kind_t kind_of(input logic [7:0] code);
    if (!ctrl_reg[`CTRL_EN_BIT])
      return rl_parser_pkg::KIND_OTHER;
    else if (code == kind_rl_reg)
      return rl_parser_pkg::KIND_RL;
    else if (code == kind_upd_reg && ctrl_reg[`CTRL_UPD_BIT])
      return rl_parser_pkg::KIND_UPD;
    else
      return rl_parser_pkg::KIND_OTHER;
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    return a == `ADDR_CTRL || a == `ADDR_KIND || a == `ADDR_RL_ID || a == `ADDR_RL_POS ||
           a == `ADDR_RL_SHIFT || a == `ADDR_UPD || a == `ADDR_STATUS;
  endfunction

  function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                       input logic s);
    return s ? new_v : old_v;
  endfunction

  // ----------------------------------------
  // framing
  // ----------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= rl_parser_pkg::ST_KIND;
      kind_reg  <= rl_parser_pkg::KIND_OTHER;
      rem_reg   <= 8'h00;
      idx_reg   <= 8'h00;
    end else if (restart_in) begin
      state_reg <= rl_parser_pkg::ST_KIND;
    end else if (byte_valid_in) begin
      case (state_reg)
        rl_parser_pkg::ST_KIND: begin
          kind_reg  <= kind_of(byte_in); // R1 R18
          state_reg <= rl_parser_pkg::ST_LEN;
        end
        rl_parser_pkg::ST_LEN: begin
          rem_reg   <= byte_in; // R2
          idx_reg   <= 8'h00;
          state_reg <= (byte_in == 8'h00) ? rl_parser_pkg::ST_KIND : rl_parser_pkg::ST_BODY;
        end
        rl_parser_pkg::ST_BODY: begin
          rem_reg <= rem_reg - 8'h01; // R2
          idx_reg <= idx_reg + 8'h01;
          if (rem_reg == 8'h01)
            state_reg <= rl_parser_pkg::ST_KIND;
        end
        default: state_reg <= rl_parser_pkg::ST_KIND;
      endcase
    end
  end

  // ----------------------------------------
  // return link fields
  // ----------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sc_work_reg            <= 8'h00;
      spot_work_reg          <= 16'h0000;
      hub_work_reg           <= 8'h00;
      slot_work_reg          <= 16'h0000;
      east_work_reg          <= 1'b0;
      frame_work_reg         <= 8'h00;
      shift_work_reg         <= 16'h0000;
      spacecraft_number_out  <= 8'h00;
      spot_number_out        <= 16'h0000;
      hub_station_number_out <= 8'h00;
      orbital_slot_out       <= 16'h0000;
      hemisphere_east_out    <= 1'b0;
      frame_group_select_out <= 8'h00;
      freq_shift_out         <= 24'h000000;
      freq_shift_apply_out   <= 1'b0;
      rl_done_out            <= 1'b0;
      vendor_byte_out        <= 8'h00;
      vendor_valid_out       <= 1'b0;
      rl_count_reg           <= 8'h00;
    end else begin
      rl_done_out      <= 1'b0;
      vendor_valid_out <= 1'b0;
      if (body_byte && kind_reg == rl_parser_pkg::KIND_RL) begin
        case (idx_reg) // R3
          8'h00:             sc_work_reg          <= byte_in; // R6
          `RL_OFS_SPOT_HI:   spot_work_reg[15:8]  <= byte_in; // R7
          `RL_OFS_SPOT_LO:   spot_work_reg[7:0]   <= byte_in;
          `RL_OFS_HUB:       hub_work_reg         <= byte_in; // R8
          `RL_OFS_RSVD:      ;                                // R4
          `RL_OFS_SLOT_HI:   slot_work_reg[15:8]  <= byte_in; // R9
          `RL_OFS_SLOT_LO:   slot_work_reg[7:0]   <= byte_in;
          `RL_OFS_HEMI:      east_work_reg        <= byte_in[0]; // R4 R10
          `RL_OFS_FRAME:     frame_work_reg       <= byte_in; // R11
          `RL_OFS_SHIFT_HI:  shift_work_reg[15:8] <= byte_in; // R12
          `RL_OFS_SHIFT_MID: shift_work_reg[7:0]  <= byte_in;
          `RL_OFS_SHIFT_LO: begin
            // fields publish together so readers never see a half-updated set
            spacecraft_number_out  <= sc_work_reg;
            spot_number_out        <= spot_work_reg;
            hub_station_number_out <= hub_work_reg;
            orbital_slot_out       <= slot_work_reg;
            hemisphere_east_out    <= east_work_reg;
            frame_group_select_out <= frame_work_reg;
            if (!broadcast_in)
              freq_shift_out <= {shift_work_reg, byte_in}; // R12 R13
            freq_shift_apply_out   <= !broadcast_in; // R13
            rl_done_out            <= 1'b1;
            rl_count_reg           <= rl_count_reg + 8'h01;
          end
          default: begin
            vendor_byte_out  <= byte_in; // R14
            vendor_valid_out <= 1'b1;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // table update notice
  // ----------------------------------------
  // notices never touch header version tracking, which runs elsewhere  R19
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      network_number_out  <= 16'h0000;
      code_work_reg       <= 8'h00;
      table_kind_code_out <= 8'h00;
      revision_out        <= 5'h00;
      entry_valid_out     <= 1'b0;
      entry_count_reg     <= 8'h00;
      partial_count_reg   <= 8'h00;
    end else begin
      entry_valid_out <= 1'b0;
      if (body_byte && kind_reg == rl_parser_pkg::KIND_UPD) begin // R15
        if (idx_reg == 8'h00)
          network_number_out[15:8] <= byte_in;
        else if (idx_reg == `UPD_OFS_NET_LO)
          network_number_out[7:0] <= byte_in;
        else if (!idx_reg[0]) begin
          code_work_reg <= byte_in; // R16 R20
          if (body_last)
            partial_count_reg <= partial_count_reg + 8'h01; // R23
        end else begin
          table_kind_code_out <= code_work_reg; // R16 R20
          revision_out        <= byte_in[4:0]; // R4 R17
          entry_valid_out     <= 1'b1; // R22 R23
          entry_count_reg     <= entry_count_reg + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      awready_out  <= 1'b1;
      wready_out   <= 1'b1;
      bvalid_out   <= 1'b0;
      bresp_out    <= `RESP_OKAY;
      aw_have_reg  <= 1'b0;
      w_have_reg   <= 1'b0;
      aw_addr_reg  <= 8'h00;
      w_data_reg   <= 32'h00000000;
      w_strb_reg   <= 4'h0;
      ctrl_reg     <= `CTRL_RESET;
      kind_rl_reg  <= `KIND_RL_RESET;
      kind_upd_reg <= `KIND_UPD_RESET;
    end else begin
      if (awvalid_in && awready_out) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= awaddr_in;
        awready_out <= 1'b0;
      end
      if (wvalid_in && wready_out) begin
        w_have_reg  <= 1'b1;
        w_data_reg  <= wdata_in;
        w_strb_reg  <= wstrb_in;
        wready_out  <= 1'b0;
      end
      if (aw_have_reg && w_have_reg && !bvalid_out) begin
        bvalid_out  <= 1'b1;
        bresp_out   <= addr_ok(aw_addr_reg) ? `RESP_OKAY : `RESP_SLVERR;
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
        if (aw_addr_reg == `ADDR_CTRL && w_strb_reg[0])
          ctrl_reg <= w_data_reg[1:0];
        if (aw_addr_reg == `ADDR_KIND) begin
          kind_rl_reg  <= merge(kind_rl_reg, w_data_reg[7:0], w_strb_reg[0]);
          kind_upd_reg <= merge(kind_upd_reg, w_data_reg[15:8], w_strb_reg[1]);
        end
      end
      if (bvalid_out && bready_in) begin
        bvalid_out  <= 1'b0;
        awready_out <= 1'b1;
        wready_out  <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      arready_out <= 1'b1;
      rvalid_out  <= 1'b0;
      rdata_out   <= 32'h00000000;
      rresp_out   <= `RESP_OKAY;
    end else if (arvalid_in && arready_out) begin
      arready_out <= 1'b0;
      rvalid_out  <= 1'b1;
      rresp_out   <= addr_ok(araddr_in) ? `RESP_OKAY : `RESP_SLVERR;
      case (araddr_in)
        `ADDR_CTRL:     rdata_out <= {30'h0, ctrl_reg};
        `ADDR_KIND:     rdata_out <= {16'h0000, kind_upd_reg, kind_rl_reg};
        `ADDR_RL_ID:    rdata_out <= {hub_station_number_out, spot_number_out,
                                      spacecraft_number_out};
        `ADDR_RL_POS:   rdata_out <= {frame_group_select_out, 7'h00, hemisphere_east_out,
                                      orbital_slot_out};
        `ADDR_RL_SHIFT: rdata_out <= {7'h00, freq_shift_apply_out, freq_shift_out};
        `ADDR_UPD:      rdata_out <= {3'h0, revision_out, table_kind_code_out,
                                      network_number_out};
        `ADDR_STATUS:   rdata_out <= {8'h00, partial_count_reg, entry_count_reg, rl_count_reg};
        default:        rdata_out <= 32'h00000000;
      endcase
    end else if (rvalid_out && rready_in) begin
      rvalid_out  <= 1'b0;
      arready_out <= 1'b1;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_kind_byte;
    byte_valid_in && !restart_in && state_reg == rl_parser_pkg::ST_KIND;
  endsequence
  sequence s_len_byte;
    byte_valid_in && !restart_in && state_reg == rl_parser_pkg::ST_LEN && byte_in != 8'h00;
  endsequence

  property p_kind;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    s_kind_byte |=> state_reg == rl_parser_pkg::ST_LEN &&
                    kind_reg == kind_of($past(byte_in));
  endproperty
  a_kind: assert property (p_kind) else $error("kind byte not taken"); // R1

  property p_len;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    s_len_byte ##1 (!byte_valid_in && !restart_in) [*2] |->
      rem_reg == $past(byte_in, 2) && state_reg == rl_parser_pkg::ST_BODY;
  endproperty
  a_len: assert property (p_len) else $error("length not held"); // R2

  property p_rl_done;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    rl_done_out |-> $past(idx_reg) == `RL_OFS_SHIFT_LO &&
                    $past(kind_reg) == rl_parser_pkg::KIND_RL;
  endproperty
  a_rl_done: assert property (p_rl_done) else $error("return link done at wrong byte"); // R3

  property p_hemi;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    rl_done_out |-> hemisphere_east_out == $past(east_work_reg) &&
                    spot_number_out == $past(spot_work_reg);
  endproperty
  a_hemi: assert property (p_hemi) else $error("position fields wrong"); // R10

  property p_bcast;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    rl_done_out && !freq_shift_apply_out |-> $stable(freq_shift_out);
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast shift applied"); // R13

  property p_vendor;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    vendor_valid_out |-> $past(idx_reg) > `RL_OFS_SHIFT_LO && vendor_byte_out == $past(byte_in);
  endproperty
  a_vendor: assert property (p_vendor) else $error("vendor byte wrong"); // R14

  property p_entry;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    entry_valid_out |-> $past(idx_reg[0]) && $past(idx_reg) > `UPD_OFS_NET_LO &&
                        revision_out == $past(byte_in[4:0]);
  endproperty
  a_entry: assert property (p_entry) else $error("update entry wrong"); // R17

  property p_partial;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    body_last && kind_reg == rl_parser_pkg::KIND_UPD && !idx_reg[0] |=> !entry_valid_out;
  endproperty
  a_partial: assert property (p_partial) else $error("partial entry raised"); // R23

  property p_discard;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    s_kind_byte and (!ctrl_reg[`CTRL_UPD_BIT] && byte_in == kind_upd_reg) |=>
      kind_reg != rl_parser_pkg::KIND_UPD ##1 !entry_valid_out;
  endproperty
  a_discard: assert property (p_discard) else $error("notice not discarded"); // R18

endmodule // rl_parser
`default_nettype wire

// file: hw/rl_parser_defines.svh
// register map, field positions, reset values and byte offsets of the parser
// assumes inclusion by the parser module only
`ifndef RL_PARSER_DEFINES_SVH
`define RL_PARSER_DEFINES_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define ADDR_CTRL      8'h00
`define ADDR_KIND      8'h04
`define ADDR_RL_ID     8'h08
`define ADDR_RL_POS    8'h0c
`define ADDR_RL_SHIFT  8'h10
`define ADDR_UPD       8'h14
`define ADDR_STATUS    8'h18

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define CTRL_EN_BIT       0
`define CTRL_UPD_BIT      1
`define CTRL_RESET        2'h3
`define KIND_RL_RESET     8'h01
`define KIND_UPD_RESET    8'h02
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

// ----------------------------------------
// body byte offsets
// ----------------------------------------
`define RL_OFS_SPOT_HI    8'h01
`define RL_OFS_SPOT_LO    8'h02
`define RL_OFS_HUB        8'h03
`define RL_OFS_RSVD       8'h04
`define RL_OFS_SLOT_HI    8'h05
`define RL_OFS_SLOT_LO    8'h06
`define RL_OFS_HEMI       8'h07
`define RL_OFS_FRAME      8'h08
`define RL_OFS_SHIFT_HI   8'h09
`define RL_OFS_SHIFT_MID  8'h0a
`define RL_OFS_SHIFT_LO   8'h0b
`define UPD_OFS_NET_LO    8'h01
`define UPD_OFS_LIST      8'h02
`define SHIFT_STEP_HZ     100

`endif

// file: hw/rl_parser_pkg.sv
// types shared by the descriptor parser
// assumes nothing of its surroundings
`default_nettype none
package rl_parser_pkg;
  typedef enum logic [1:0] {ST_KIND, ST_LEN, ST_BODY} parse_state_t;
  typedef enum logic [1:0] {KIND_RL, KIND_UPD, KIND_OTHER} desc_kind_t;
endpackage
`default_nettype wire

// file: sim/return_link_and_table_update_parser_tb.sv
// self-checking bench for the descriptor parser and its register slave
// assumes rl_parser and section_source are compiled before it
`default_nettype none
module return_link_and_table_update_parser_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst_n = 1'b0, broadcast = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, bval, rstrt, east, apply, done;
  logic        vvalid, entv;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  bdat, sc, hub, frame, vbyte, code;
  logic [15:0] spot, slot, net;
  logic [23:0] shift;
  logic [4:0]  rev;
  logic [3:0]  wstrb = 4'hf;
  logic [7:0]  ven_q[$];
  logic [12:0] ent_q[$];
  int          rl_cnt = 0, n_mismatch = 0, samples_checked = 0;

  always #10 clk = ~clk;

  section_source src (.clk_in(clk), .byte_out(bdat), .valid_out(bval), .restart_out(rstrt));

  rl_parser uut (.ref_clk_in(clk), .rst_n_in(rst_n), .awaddr_in(awaddr), .awvalid_in(awvalid),
    .awready_out(awready), .wdata_in(wdata), .wstrb_in(wstrb), .wvalid_in(wvalid),
    .wready_out(wready), .bresp_out(bresp), .bvalid_out(bvalid), .bready_in(bready),
    .araddr_in(araddr), .arvalid_in(arvalid), .arready_out(arready), .rdata_out(rdata),
    .rresp_out(rresp), .rvalid_out(rvalid), .rready_in(rready), .byte_in(bdat),
    .byte_valid_in(bval), .restart_in(rstrt), .broadcast_in(broadcast),
    .spacecraft_number_out(sc), .spot_number_out(spot), .hub_station_number_out(hub),
    .orbital_slot_out(slot), .hemisphere_east_out(east), .frame_group_select_out(frame),
    .freq_shift_out(shift), .freq_shift_apply_out(apply), .rl_done_out(done),
    .vendor_byte_out(vbyte), .vendor_valid_out(vvalid), .network_number_out(net),
    .table_kind_code_out(code), .revision_out(rev), .entry_valid_out(entv));

  // pulses last one cycle, so they are caught at every edge
  always @(posedge clk) begin
    if (done === 1'b1) rl_cnt++;
    if (vvalid === 1'b1) ven_q.push_back(vbyte);
    if (entv === 1'b1) ent_q.push_back({code, rev});
  end

  // -------------------------------------------
  // shared tasks
  // -------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // no cycle limit here: only the watchdog ends a wait for the slave
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic send_rl(input logic [7:0] s, rs, hb, input logic [23:0] sh);
    logic [7:0] q[$];
    q = {8'h01, 8'h0d, s, 8'hc3, 8'ha7, 8'h81, rs, 8'h01, 8'h92, hb, 8'h3c,
         sh[23:16], sh[15:8], sh[7:0], 8'h99};
    src.send(q, 0);
    repeat (3) @(posedge clk);
  endtask

  // -------------------------------------------
  // scenarios
  // -------------------------------------------
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(8'h00, d, r); chk(d, 32'h3);
    axi_rd(8'h04, d, r); chk(d, 32'h0201); chk(r, 2'h0);
    axi_rd(8'h40, d, r); chk(d, 32'h0); chk(r, 2'h2);
    axi_wr(8'h40, 32'hffff_ffff, r); chk(r, 2'h2);
    axi_wr(8'h18, 32'hffff_ffff, r); chk(r, 2'h0);
    axi_rd(8'h18, d, r); chk(d, 32'h0);
  endtask

  task automatic t_rl();
    logic [31:0] d;
    logic [1:0]  r;
    send_rl(8'h5a, 8'he7, 8'hfe, 24'hfff85e);
    chk(rl_cnt, 1);
    chk(sc, 8'h5a); chk(spot, 16'hc3a7); chk(hub, 8'h81);
    chk(slot, 16'h0192); chk(east, 1'b0);
    chk(frame, 8'h3c); chk(shift, 24'hfff85e); chk(apply, 1'b1);
    chk(ven_q.size(), 1); chk(ven_q[0], 8'h99);
    axi_rd(8'h08, d, r); chk(d, 32'h81c3a75a);
  endtask

  // reserved bits differ from the first pass and must change nothing
  task automatic t_bcast();
    broadcast <= 1'b1;
    send_rl(8'h11, 8'h18, 8'h01, 24'h000123);
    chk(rl_cnt, 2); chk(sc, 8'h11); chk(east, 1'b1);
    chk(shift, 24'hfff85e); chk(apply, 1'b0);
    broadcast <= 1'b0;
  endtask

  // unknown kind skipped by its length, then a gapped notice with a half entry
  task automatic t_upd();
    logic [7:0]  q[$];
    logic [31:0] d;
    logic [1:0]  r;
    q = {8'h77, 8'h03, 8'h01, 8'h0d, 8'h02,
         8'h02, 8'h07, 8'hbe, 8'hef, 8'h4e, 8'he5, 8'h41, 8'h1f, 8'h70};
    src.send(q, 2);
    repeat (3) @(posedge clk);
    chk(net, 16'hbeef); chk(ent_q.size(), 2);
    chk(ent_q[0], {8'h4e, 5'h05}); chk(ent_q[1], {8'h41, 5'h1f});
    axi_rd(8'h18, d, r); chk(d, 32'h00010202);
  endtask

  task automatic t_off();
    logic [7:0]  q[$];
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(8'h00, 32'h1, r);
    q = {8'h02, 8'h04, 8'h12, 8'h34, 8'h55, 8'h03};
    src.send(q, 0);
    repeat (3) @(posedge clk);
    chk(ent_q.size(), 2); chk(net, 16'hbeef);
    axi_wr(8'h00, 32'h3, r);
    // low strobe only: the update code must keep its old value
    wstrb <= 4'h1;
    axi_wr(8'h04, 32'h0000_0b0a, r);
    wstrb <= 4'hf;
    axi_rd(8'h04, d, r);
    chk(d, 32'h0000_020a);
    // old return link code is now unknown, its zero length hands over to a notice
    q = {8'h01, 8'h00, 8'h02, 8'h04, 8'h12, 8'h34, 8'h56, 8'h3e};
    src.send(q, 0);
    repeat (3) @(posedge clk);
    chk(ent_q.size(), 3);
    chk(ent_q[2], {8'h56, 5'h1e});
    chk(net, 16'h1234);
  endtask

  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    close_out();
  end

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    src.resync();
    t_regs();
    t_rl();
    t_bcast();
    t_upd();
    t_off();
    close_out();
  end
endmodule // return_link_and_table_update_parser_tb
`default_nettype wire

// file: sim/section_source.sv
// section filter model: hands descriptor bytes to the parser one per strobe
// assumes a free-running clock from the bench; the bench calls its tasks
`default_nettype none
module section_source (
  input  wire logic       clk_in,       // bench clock
  output logic [7:0]      byte_out,     // descriptor byte
  output logic            valid_out,    // byte strobe
  output logic            restart_out   // next byte is a kind code
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    byte_out    = 8'h00;
    valid_out   = 1'b0;
    restart_out = 1'b0;
  end

  // -------------------------------------------
  // byte delivery
  // -------------------------------------------
  // idle cycles show the inverted byte so a stale value never looks valid
  task automatic send(input logic [7:0] b[$], input int gap);
    foreach (b[i]) begin
      @(posedge clk_in);
      byte_out  <= b[i];
      valid_out <= 1'b1;
      repeat (gap) begin
        @(posedge clk_in);
        valid_out <= 1'b0;
        byte_out  <= ~b[i];
      end
    end
    @(posedge clk_in);
    valid_out <= 1'b0;
    byte_out  <= ~b[b.size()-1];
  endtask

  task automatic resync();
    @(posedge clk_in);
    restart_out <= 1'b1;
    @(posedge clk_in);
    restart_out <= 1'b0;
  endtask
endmodule // section_source
`default_nettype wire
